/* inc/cot_pkg.sv */
package cot_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_ADDR = 8'h37;
	localparam logic [15:0] RESET_VALUE = 16'h1240;
	// Bits that software may change; status and reserved bits are excluded
	localparam logic [15:0] WRITE_MASK = 16'h96FC;

	localparam int DISCHARGE_REG_EN_BIT = 15;
	localparam int DEGLITCH_SEL_BIT = 12;
	localparam int ADAPTER_STAT_BIT = 11;
	localparam int OVERCURRENT_EN_BIT = 10;
	localparam int OVERCURRENT_LIM_BIT = 9;
	localparam int HIGH_SIDE_BIT = 7;
	localparam int LOW_SIDE_BIT = 6;
	localparam int FAST_THRESH_BIT = 5;
	localparam int FAST_RESP_LSB = 3;
	localparam int BOOST_EN_BIT = 2;
	localparam int BOOST_STAT_BIT = 1;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 20000000;
	localparam int unsigned SHORT_DEG_MS = 150;
	// 1.3 s held in milliseconds
	localparam int unsigned LONG_DEG_MS = 1300;
	localparam int unsigned RESP_DEFAULT_US = 150;
	localparam int unsigned RESP_SLOW_US = 250;
	localparam int unsigned RESP_FAST_US = 50;

	localparam int unsigned SHORT_DEG_CYC = (SHORT_DEG_MS * (CLK_FREQ_HZ / 1000) + 0) / 1;
	localparam int unsigned LONG_DEG_CYC = LONG_DEG_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned RESP_DEFAULT_CYC = RESP_DEFAULT_US * (CLK_FREQ_HZ / 1000000);
	localparam int unsigned RESP_SLOW_CYC = RESP_SLOW_US * (CLK_FREQ_HZ / 1000000);
	localparam int unsigned RESP_FAST_CYC = RESP_FAST_US * (CLK_FREQ_HZ / 1000000);

	localparam logic [1:0] RESP_CODE_DEFAULT = 2'h0;
	localparam logic [1:0] RESP_CODE_SLOW = 2'h1;

endpackage : cot_pkg

/* rtl/cot_rise_deglitch.sv */
`timescale 1ns/100ps

module cot_rise_deglitch #(
	parameter int unsigned CNT_W = 25
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic level,
	input wire logic [CNT_W-1:0] limit,
	output logic qualified
);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic next_qualified;

	// ------------------------------------------------------------
	// Rising edge is delayed, falling edge passes at once
	// ------------------------------------------------------------
	always_comb begin
		next_count = count;
		next_qualified = qualified;
		if (!level) begin
			next_count = '0;
			next_qualified = 1'h0;
		end else if (!qualified) begin
			if (count >= limit - 1'h1) begin
				next_qualified = 1'h1;
			end else begin
				next_count = count + 1'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
			qualified <= 1'h0;
		end else begin
			count <= next_count;
			qualified <= next_qualified;
		end
	end

endmodule : cot_rise_deglitch

/* rtl/cot_charge_option3.sv */
`timescale 1ns/100ps


module cot_charge_option3 #(
	parameter int unsigned CNT_W = 25,
	parameter int unsigned SHORT_DEG_CYC = cot_pkg::SHORT_DEG_CYC,
	parameter int unsigned LONG_DEG_CYC = cot_pkg::LONG_DEG_CYC,
	parameter int unsigned RESP_DEFAULT_CYC = cot_pkg::RESP_DEFAULT_CYC,
	parameter int unsigned RESP_SLOW_CYC = cot_pkg::RESP_SLOW_CYC,
	parameter int unsigned RESP_FAST_CYC = cot_pkg::RESP_FAST_CYC
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	output logic [15:0] regRdata,
	input wire logic adapterDetectInput,
	input wire logic fastLimitTrip,
	input wire logic batteryPresentN,
	output logic adapterPresentPin,
	output logic inputPowerFetOn,
	output logic reverseBlockFetOn,
	output logic dischargeRegEnable,
	output logic inputOvercurrentEnable,
	output logic inputOvercurrentLimitSel,
	output logic highSideShortEnable,
	output logic lowSideShortEnable,
	output logic fastLimitThresholdSel,
	output logic boostEnable,
	output logic boostActive
);

	logic [15:0] ctrl;
	logic [15:0] next_ctrl;
	logic [15:0] next_regRdata;
	logic [15:0] readValue;
	logic firstDone;
	logic next_firstDone;
	logic batPrev;
	logic next_batPrev;
	logic batRemoved;
	logic addrHit;
	logic [CNT_W-1:0] adapterLimit;
	logic [CNT_W-1:0] respLimit;

	function automatic logic [CNT_W-1:0] resp_cycles(input logic [1:0] code);
		if (code == cot_pkg::RESP_CODE_DEFAULT) begin
			resp_cycles = CNT_W'(RESP_DEFAULT_CYC);
		end else if (code == cot_pkg::RESP_CODE_SLOW) begin
			resp_cycles = CNT_W'(RESP_SLOW_CYC);
		end else begin
			resp_cycles = CNT_W'(RESP_FAST_CYC);
		end
	endfunction : resp_cycles

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	assign addrHit = (regAddr == cot_pkg::REG_ADDR);
	// Removal acts on the first edge that samples the pin high
	assign batRemoved = batteryPresentN && !batPrev;

	always_comb begin
		next_ctrl = ctrl;
		if (regWrite && addrHit) begin
			next_ctrl = regWdata & cot_pkg::WRITE_MASK;
		end
		// Removal wins over a simultaneous software set: boost on no battery is unsafe
		if (batRemoved) begin
			next_ctrl[cot_pkg::BOOST_EN_BIT] = 1'h0;
		end
	end

	always_comb begin
		readValue = ctrl & cot_pkg::WRITE_MASK;
		readValue[cot_pkg::ADAPTER_STAT_BIT] = adapterPresentPin;
		readValue[cot_pkg::BOOST_STAT_BIT] = boostActive;
		next_regRdata = (regRead && addrHit) ? readValue : 16'h0000;
	end

	always_comb begin
		next_firstDone = firstDone | adapterPresentPin;
		next_batPrev = batteryPresentN;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= cot_pkg::RESET_VALUE;
			regRdata <= 16'h0000;
			firstDone <= 1'h0;
			batPrev <= 1'h0;
		end else begin
			ctrl <= next_ctrl;
			regRdata <= next_regRdata;
			firstDone <= next_firstDone;
			batPrev <= next_batPrev;
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	assign dischargeRegEnable = ctrl[cot_pkg::DISCHARGE_REG_EN_BIT];
	assign inputOvercurrentEnable = ctrl[cot_pkg::OVERCURRENT_EN_BIT];
	assign inputOvercurrentLimitSel = ctrl[cot_pkg::OVERCURRENT_LIM_BIT];
	assign highSideShortEnable = ctrl[cot_pkg::HIGH_SIDE_BIT];
	assign lowSideShortEnable = ctrl[cot_pkg::LOW_SIDE_BIT];
	assign fastLimitThresholdSel = ctrl[cot_pkg::FAST_THRESH_BIT];
	assign boostEnable = ctrl[cot_pkg::BOOST_EN_BIT];

	// ------------------------------------------------------------
	// Adapter present deglitch
	// ------------------------------------------------------------
	always_comb begin
		if (!firstDone || !ctrl[cot_pkg::DEGLITCH_SEL_BIT]) begin
			adapterLimit = CNT_W'(SHORT_DEG_CYC);
		end else begin
			adapterLimit = CNT_W'(LONG_DEG_CYC);
		end
	end

	cot_rise_deglitch #(
		.CNT_W(CNT_W)
	) adapterDeglitch (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level(adapterDetectInput),
		.limit(adapterLimit),
		.qualified(adapterPresentPin)
	);

	// FETs follow the deglitched pin, so a short re-arms the full deglitch
	assign inputPowerFetOn = adapterPresentPin;
	assign reverseBlockFetOn = adapterPresentPin;

	// ------------------------------------------------------------
	// Boost entry timing
	// ------------------------------------------------------------
	assign respLimit = resp_cycles(ctrl[cot_pkg::FAST_RESP_LSB +: 2]);

	cot_rise_deglitch #(
		.CNT_W(CNT_W)
	) boostDeglitch (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.level(boostEnable && fastLimitTrip),
		.limit(respLimit),
		.qualified(boostActive)
	);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_write;
		regWrite && addrHit;
	endsequence

	sequence s_read;
		regRead && addrHit;
	endsequence

	property p_discharge;
		@(posedge ref_clk) disable iff (!rst_b)
		s_write |=> dischargeRegEnable == $past(regWdata[cot_pkg::DISCHARGE_REG_EN_BIT]);
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge enable not written");

	property p_first_deglitch;
		@(posedge ref_clk) disable iff (!rst_b)
		!firstDone |-> adapterLimit == CNT_W'(SHORT_DEG_CYC);
	endproperty
	a_first_deglitch: assert property (p_first_deglitch) else $error("first deglitch not short");

	property p_later_deglitch;
		@(posedge ref_clk) disable iff (!rst_b)
		firstDone && ctrl[cot_pkg::DEGLITCH_SEL_BIT] |-> adapterLimit == CNT_W'(LONG_DEG_CYC);
	endproperty
	a_later_deglitch: assert property (p_later_deglitch) else $error("later deglitch wrong");

	property p_later_short;
		@(posedge ref_clk) disable iff (!rst_b)
		firstDone && !ctrl[cot_pkg::DEGLITCH_SEL_BIT] |->
			adapterLimit == CNT_W'(SHORT_DEG_CYC);
	endproperty
	a_later_short: assert property (p_later_short) else $error("later short deglitch wrong");

	property p_fet_off;
		@(posedge ref_clk) disable iff (!rst_b)
		!adapterDetectInput |=> !inputPowerFetOn && !reverseBlockFetOn ##1 !adapterPresentPin;
	endproperty
	a_fet_off: assert property (p_fet_off) else $error("FETs not off after detect drop");

	property p_status_read;
		@(posedge ref_clk) disable iff (!rst_b)
		s_read |=> regRdata[cot_pkg::ADAPTER_STAT_BIT] == $past(adapterPresentPin) &&
			regRdata[cot_pkg::BOOST_STAT_BIT] == $past(boostActive);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status bits misread");

	property p_protect;
		@(posedge ref_clk) disable iff (!rst_b)
		s_write |=> {inputOvercurrentEnable, inputOvercurrentLimitSel, highSideShortEnable,
			lowSideShortEnable, fastLimitThresholdSel} == $past({regWdata[10:9], regWdata[7:5]});
	endproperty
	a_protect: assert property (p_protect) else $error("protection bits not written");

	property p_resp;
		@(posedge ref_clk) disable iff (!rst_b)
		ctrl[cot_pkg::FAST_RESP_LSB + 1] |-> respLimit == CNT_W'(RESP_FAST_CYC);
	endproperty
	a_resp: assert property (p_resp) else $error("fast response code wrong");

	property p_removal;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(batteryPresentN) |=> !boostEnable ##1 !boostActive;
	endproperty
	a_removal: assert property (p_removal) else $error("boost kept after removal");

	property p_boost_stat;
		@(posedge ref_clk) disable iff (!rst_b)
		boostActive |-> $past(boostEnable) && $past(fastLimitTrip);
	endproperty
	a_boost_stat: assert property (p_boost_stat) else $error("boost status without cause");

	property p_reserved;
		@(posedge ref_clk) disable iff (!rst_b)
		s_read |=> regRdata[14:13] == 2'h0 && !regRdata[8] && !regRdata[0];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

endmodule : cot_charge_option3

/* testbench/cot_host_model.sv */
`timescale 1ns/100ps

module cot_host_model #(
	parameter int INPUT_LIMIT_MA = 1536
) (
	input wire logic ref_clk,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [15:0] regWdata,
	input wire logic [15:0] regRdata
);
	// ----------------------------------------
	// Host side of the register port
	// ----------------------------------------
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
	end

	// Released lines show the inverse so that stale values are never mistaken for data
	task automatic release_bus();
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = ~regAddr;
		regWdata = ~regWdata;
	endtask : release_bus

	task automatic wr(input logic [7:0] addr, input logic [15:0] data);
		@(posedge ref_clk);
		#5;
		regAddr = addr;
		// Boost stays off unless the input current limit is high enough
		regWdata = (INPUT_LIMIT_MA < 1536) ? (data & 16'hFFFB) : data;
		regWrite = 1'b1;
		@(posedge ref_clk);
		#5;
		release_bus();
	endtask : wr

	task automatic rd(input logic [7:0] addr, output logic [15:0] data);
		@(posedge ref_clk);
		#5;
		regAddr = addr;
		regRead = 1'b1;
		@(posedge ref_clk);
		#5;
		data = regRdata;
		release_bus();
	endtask : rd
endmodule : cot_host_model

/* testbench/tb_top.sv */
`timescale 1ns/100ps

module tb_top;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic adapterDetectInput = 1'b0;
	logic fastLimitTrip = 1'b0;
	logic batteryPresentN = 1'b0;
	logic regWrite, regRead, adapterPresentPin, inputPowerFetOn, reverseBlockFetOn;
	logic dischargeRegEnable, inputOvercurrentEnable, inputOvercurrentLimitSel;
	logic highSideShortEnable, lowSideShortEnable, fastLimitThresholdSel;
	logic boostEnable, boostActive;
	logic [7:0] regAddr;
	logic [15:0] regWdata, regRdata, rd;
	logic [6:0] ctl;
	int nErrors = 0;
	int checks = 0;
	int cycles = 0;

	// ----------------------------------------
	// Plumbing
	// ----------------------------------------
	always #25 ref_clk = ~ref_clk;

	assign ctl = {dischargeRegEnable, inputOvercurrentEnable, inputOvercurrentLimitSel,
		highSideShortEnable, lowSideShortEnable, fastLimitThresholdSel, boostEnable};

	cot_host_model i_host (.ref_clk(ref_clk), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

	// Short counts keep the deglitch and response waits to a few dozen cycles
	cot_charge_option3 #(.SHORT_DEG_CYC(20), .LONG_DEG_CYC(50), .RESP_DEFAULT_CYC(6),
		.RESP_SLOW_CYC(10), .RESP_FAST_CYC(3)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
		.regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
		.regRdata(regRdata), .adapterDetectInput(adapterDetectInput),
		.fastLimitTrip(fastLimitTrip), .batteryPresentN(batteryPresentN),
		.adapterPresentPin(adapterPresentPin), .inputPowerFetOn(inputPowerFetOn),
		.reverseBlockFetOn(reverseBlockFetOn), .dischargeRegEnable(dischargeRegEnable),
		.inputOvercurrentEnable(inputOvercurrentEnable),
		.inputOvercurrentLimitSel(inputOvercurrentLimitSel),
		.highSideShortEnable(highSideShortEnable), .lowSideShortEnable(lowSideShortEnable),
		.fastLimitThresholdSel(fastLimitThresholdSel), .boostEnable(boostEnable),
		.boostActive(boostActive));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, nErrors);
		if (nErrors == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 2000) begin
			nErrors++;
			$display("unexpected at %0t: run did not finish", $time);
			finish_test();
		end
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checks++;
		if (got !== exp) begin
			nErrors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : cmp

	function automatic logic [6:0] exp_ctl(input logic [15:0] r);
		return {r[15], r[10], r[9], r[7], r[6], r[5], r[2]};
	endfunction : exp_ctl

	function automatic logic sel(input int w);
		return w ? boostActive : adapterPresentPin;
	endfunction : sel

	task automatic chk_reg(input logic [15:0] v, input string msg);
		i_host.rd(8'h37, rd);
		cmp(rd, v, msg);
		cmp({9'h000, ctl}, {9'h000, exp_ctl(v)}, msg);
	endtask : chk_reg

	// Low until just before n cycles, then high within a small window
	task automatic chk_rise(input int w, input int n, input string msg);
		int k;
		k = 0;
		repeat (n - 2) @(posedge ref_clk);
		#5;
		cmp(16'(sel(w)), 16'h0000, msg);
		while (sel(w) !== 1'b1 && k < 5) begin
			@(posedge ref_clk);
			#5;
			k++;
		end
		cmp(16'(sel(w)), 16'h0001, msg);
	endtask : chk_rise

	task automatic plug(input int n, input string msg);
		adapterDetectInput = 1'b0;
		repeat (2) @(posedge ref_clk);
		#5;
		cmp(16'(adapterPresentPin), 16'h0000, "unplug");
		i_host.rd(8'h37, rd);
		cmp(rd & 16'h0800, 16'h0000, "status after unplug");
		adapterDetectInput = 1'b1;
		chk_rise(0, n, msg);
	endtask : plug

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_regs();
		chk_reg(16'h1240, "reset value");
		i_host.wr(8'h37, 16'hFFFF);
		chk_reg(16'h96FC, "all ones");
		i_host.wr(8'h37, 16'h0000);
		chk_reg(16'h0000, "all zeros");
		i_host.wr(8'h38, 16'hFFFF);
		chk_reg(16'h0000, "unmapped write");
		i_host.rd(8'h38, rd);
		cmp(rd, 16'h0000, "unmapped read");
		i_host.wr(8'h37, 16'h1240);
		$display("test regs done");
	endtask : test_regs

	task automatic test_adapter();
		adapterDetectInput = 1'b1;
		repeat (10) @(posedge ref_clk);
		#5;
		adapterDetectInput = 1'b0;
		cmp(16'(adapterPresentPin), 16'h0000, "short glitch");
		repeat (2) @(posedge ref_clk);
		#5;
		adapterDetectInput = 1'b1;
		chk_rise(0, 20, "first insertion");
		cmp({14'h0000, inputPowerFetOn, reverseBlockFetOn}, 16'h0003, "fets on");
		i_host.rd(8'h37, rd);
		cmp(rd & 16'h0800, 16'h0800, "adapter status");
		plug(50, "second insertion");
		i_host.wr(8'h37, 16'h0240);
		plug(20, "third insertion");
		$display("test adapter done");
	endtask : test_adapter

	task automatic test_boost();
		int resp[4] = '{6, 10, 3, 3};
		logic [15:0] v;
		for (int c = 0; c < 4; c++) begin
			v = 16'h0044 | (16'(c) << 3);
			i_host.wr(8'h37, v);
			fastLimitTrip = 1'b1;
			chk_rise(1, resp[c], "boost response");
			i_host.rd(8'h37, rd);
			cmp(rd, v | 16'h0802, "boost status");
			fastLimitTrip = 1'b0;
			repeat (2) @(posedge ref_clk);
			#5;
			cmp(16'(boostActive), 16'h0000, "boost exit");
		end
		fastLimitTrip = 1'b1;
		chk_rise(1, 3, "boost again");
		batteryPresentN = 1'b1;
		repeat (4) @(posedge ref_clk);
		#5;
		cmp({14'h0000, boostEnable, boostActive}, 16'h0000, "battery removal");
		i_host.rd(8'h37, rd);
		cmp(rd & 16'h0006, 16'h0000, "boost bit cleared");
		batteryPresentN = 1'b0;
		fastLimitTrip = 1'b0;
		$display("test boost done");
	endtask : test_boost

	initial begin
		repeat (16) @(posedge ref_clk);
		#5;
		rst_b = 1'b1;
		test_regs();
		test_adapter();
		test_boost();
		finish_test();
	end
endmodule : tb_top
